// ===== logic/cssc_pkg.sv
`default_nettype none
package cssc_pkg;
	// Register addresses in the special-function register space
	localparam logic [7:0] ADDR_CONTROL = 8'hB0;
	localparam logic [7:0] ADDR_CONFIG = 8'hAA;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'hEE;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'hED;
	localparam logic [7:0] ADDR_SCAN_FIRST = 8'hDD;
	localparam logic [7:0] ADDR_SCAN_LAST = 8'hDE;
	// Control register fields
	localparam int CTL_ENABLE_BIT = 7;
	localparam int CTL_DONE_BIT = 5;
	localparam int CTL_BUSY_BIT = 4;
	// Configuration register fields
	localparam int CFG_SMEN_BIT = 7;
	localparam int CFG_TRIG_HI = 6;
	localparam int CFG_TRIG_LO = 4;
	localparam int CFG_MCEN_BIT = 3;
	localparam int CFG_ACU_HI = 2;
	localparam int CFG_ACU_LO = 0;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hF7;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// Start-trigger codes
	localparam logic [2:0] TRIG_BUSY = 3'h0;
	localparam logic [2:0] TRIG_TMR0 = 3'h1;
	localparam logic [2:0] TRIG_TMR2 = 3'h2;
	localparam logic [2:0] TRIG_TMR1 = 3'h3;
	localparam logic [2:0] TRIG_TMR3 = 3'h4;
	localparam logic [2:0] TRIG_SINGLE_SCAN = 3'h5;
	localparam logic [2:0] TRIG_CONT_CHAN = 3'h6;
	localparam logic [2:0] TRIG_AUTO_SCAN = 3'h7;
	// Timer overflow input lanes
	localparam int TMR0_LANE = 0;
	localparam int TMR1_LANE = 1;
	localparam int TMR2_LANE = 2;
	localparam int TMR3_LANE = 3;
	// Widths
	localparam int CH_W = 6;
	localparam int RES_W = 16;
	localparam int ACC_W = 22;
	localparam int CNT_W = 7;
	localparam logic [5:0] SCAN_FIELD_MASK = 6'h3F;
	// Sequencer states, Gray along idle, wait, start, wait, idle
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_START = 2'h3,
		ST_WAIT = 2'h1
	} cssc_state_t;
endpackage
`default_nettype wire

// ===== logic/cssc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Mask enable clear ignores channel mask; set limits scans to masked-in channels.
// - Trigger field bits 6:4; code 000 starts one conversion per busy write.
// - Code 001 starts on timer 0 overflow, code 010 on timer 2 overflow.
// - Code 011 starts on timer 1 overflow, code 100 on timer 3 overflow.
// - Code 101 with masking does one single scan; invalid without masking.
// - Code 110 converts continuously on selected channel after busy write.
// - Code 111 with masking auto-scans masked-in channels repeatedly.
// - Code 111 without masking scans first..last channel continuously after busy write.
// - Multi-channel bit 3 is masked off on config writes, so fe_multi stays low and no node is shorted.
// - Accumulate field bits 2:0 picks 1,4,8,16,32,64 samples; 110/111 reserved.
// - High result byte shows upper eight bits of last completed result.
// - Busy write starts only for codes 000,110 and for 111 without masking; busy reads 1 during conversion.
// - Low result byte shows lower eight bits of last completed result.
// - Done flag sets on every completed conversion; only firmware clears it.
module cssc_top #(
	parameter int NCH = 64
) (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic [7:0] sfr_addr, // Register address
	input wire logic sfr_wr, // Register write strobe
	input wire logic sfr_rd, // Register read strobe
	input wire logic [7:0] sfr_wdata, // Register write data
	output logic [7:0] sfr_rdata, // Register read data, one cycle after read
	input wire logic [3:0] tmr_ovf, // Timer overflow pulses, lane n is timer n
	input wire logic [NCH-1:0] channel_inclusion_mask, // Channels taking part in scans
	input wire logic [5:0] channel_select, // Single-channel selection
	output logic fe_start, // Front end sample start pulse
	output logic [5:0] fe_channel, // Front end channel
	output logic fe_multi, // Front end converts shorted masked-in node
	input wire logic fe_done, // Front end sample finished pulse
	input wire logic [15:0] fe_value, // Front end sample value
	output logic conversion_busy, // Conversion in progress
	output logic conversion_done_flag // Sticky conversion-done flag
);
	cssc_pkg::cssc_state_t state_ff, nxt_state;
	logic enable_ff, nxt_enable;
	logic done_ff, nxt_done;
	logic [7:0] config_ff, nxt_config;
	logic [5:0] first_ff, nxt_first;
	logic [5:0] last_ff, nxt_last;
	logic [15:0] result_ff, nxt_result;
	logic [5:0] chan_ff, nxt_chan;
	logic multi_ff, nxt_multi;
	logic [2:0] run_mode_ff, nxt_run_mode;
	logic single_pend_ff, nxt_single_pend;
	logic [21:0] acc_ff, nxt_acc;
	logic [6:0] cnt_ff, nxt_cnt;
	logic start_ff, nxt_start;
	logic [7:0] rdata_ff, nxt_rdata;
	logic busy_ff, nxt_busy;

	// Samples per result; reserved codes fall back to one sample
	function automatic logic [6:0] acc_len(input logic [2:0] code);
		case (code)
			3'h0: acc_len = 7'h01;
			3'h1: acc_len = 7'h04;
			3'h2: acc_len = 7'h08;
			3'h3: acc_len = 7'h10;
			3'h4: acc_len = 7'h20;
			3'h5: acc_len = 7'h40;
			default: acc_len = 7'h01;
		endcase
	endfunction

	// Lowest masked-in channel at or above from; bit 6 flags that one was found
	function automatic logic [6:0] find_masked(input logic [NCH-1:0] mask, input logic [6:0] from);
		find_masked = 7'h00;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (mask[i] && (i >= int'(from))) begin
				find_masked = {1'b1, i[5:0]};
			end
		end
	endfunction

	logic [2:0] trig;
	logic smen;
	logic ctl_wr;
	logic busy_wr;
	logic [6:0] first_masked;
	assign trig = config_ff[cssc_pkg::CFG_TRIG_HI:cssc_pkg::CFG_TRIG_LO];
	assign smen = config_ff[cssc_pkg::CFG_SMEN_BIT];
	assign ctl_wr = sfr_wr && (sfr_addr == cssc_pkg::ADDR_CONTROL);
	assign busy_wr = ctl_wr && sfr_wdata[cssc_pkg::CTL_BUSY_BIT];
	assign first_masked = find_masked(channel_inclusion_mask, 7'h00);

	// Next values for registers, sequencer and accumulator
	always_comb begin
		logic [21:0] sum;
		logic [6:0] nxt_masked;
		logic finish;
		logic go;
		logic [5:0] go_chan;
		sum = 22'h00_0000;
		nxt_masked = 7'h00;
		finish = 1'b0;
		go = 1'b0;
		go_chan = channel_select;
		nxt_state = state_ff;
		nxt_enable = enable_ff;
		nxt_done = done_ff;
		nxt_config = config_ff;
		nxt_first = first_ff;
		nxt_last = last_ff;
		nxt_result = result_ff;
		nxt_chan = chan_ff;
		nxt_multi = multi_ff;
		nxt_run_mode = run_mode_ff;
		nxt_single_pend = single_pend_ff;
		nxt_acc = acc_ff;
		nxt_cnt = cnt_ff;
		nxt_start = 1'b0;
		nxt_rdata = rdata_ff;

		// Software writes; the done flag only falls when firmware writes it low
		if (ctl_wr) begin
			nxt_enable = sfr_wdata[cssc_pkg::CTL_ENABLE_BIT];
			nxt_done = done_ff & sfr_wdata[cssc_pkg::CTL_DONE_BIT];
		end
		if (sfr_wr && (sfr_addr == cssc_pkg::ADDR_CONFIG)) begin
			nxt_config = sfr_wdata & cssc_pkg::CFG_WRITE_MASK;
			// Arming on the write keeps a single scan from rerunning on its own
			nxt_single_pend = (sfr_wdata[cssc_pkg::CFG_TRIG_HI:cssc_pkg::CFG_TRIG_LO] == cssc_pkg::TRIG_SINGLE_SCAN)
				&& sfr_wdata[cssc_pkg::CFG_SMEN_BIT];
		end
		if (sfr_wr && (sfr_addr == cssc_pkg::ADDR_SCAN_FIRST)) begin
			nxt_first = sfr_wdata[5:0] & cssc_pkg::SCAN_FIELD_MASK;
		end
		if (sfr_wr && (sfr_addr == cssc_pkg::ADDR_SCAN_LAST)) begin
			nxt_last = sfr_wdata[5:0] & cssc_pkg::SCAN_FIELD_MASK;
		end

		// Sequencer
		case (state_ff)
			cssc_pkg::ST_IDLE: begin
				if (enable_ff) begin
					case (trig)
						cssc_pkg::TRIG_BUSY: go = busy_wr;
						cssc_pkg::TRIG_TMR0: go = tmr_ovf[cssc_pkg::TMR0_LANE];
						cssc_pkg::TRIG_TMR2: go = tmr_ovf[cssc_pkg::TMR2_LANE];
						cssc_pkg::TRIG_TMR1: go = tmr_ovf[cssc_pkg::TMR1_LANE];
						cssc_pkg::TRIG_TMR3: go = tmr_ovf[cssc_pkg::TMR3_LANE];
						cssc_pkg::TRIG_SINGLE_SCAN: begin
							go = single_pend_ff && smen && first_masked[6];
							go_chan = first_masked[5:0];
						end
						cssc_pkg::TRIG_CONT_CHAN: go = busy_wr;
						cssc_pkg::TRIG_AUTO_SCAN: begin
							if (smen) begin
								go = first_masked[6];
								go_chan = first_masked[5:0];
							end else begin
								go = busy_wr;
								go_chan = first_ff;
							end
						end
						default: go = 1'b0;
					endcase
				end
				if (go) begin
					if (trig == cssc_pkg::TRIG_SINGLE_SCAN) begin
						nxt_single_pend = 1'b0;
					end
					nxt_chan = go_chan;
					nxt_multi = config_ff[cssc_pkg::CFG_MCEN_BIT];
					nxt_run_mode = trig;
					nxt_acc = 22'h00_0000;
					nxt_cnt = 7'h00;
					nxt_start = 1'b1;
					nxt_state = cssc_pkg::ST_WAIT;
				end
			end
			cssc_pkg::ST_START: begin
				nxt_start = 1'b1;
				nxt_state = cssc_pkg::ST_WAIT;
			end
			cssc_pkg::ST_WAIT: begin
				if (fe_done) begin
					sum = acc_ff + {6'h00, fe_value};
					nxt_acc = sum;
					nxt_cnt = cnt_ff + 7'h01;
					if ((cnt_ff + 7'h01) >= acc_len(config_ff[cssc_pkg::CFG_ACU_HI:cssc_pkg::CFG_ACU_LO])) begin
						finish = 1'b1;
					end else begin
						nxt_state = cssc_pkg::ST_START;
					end
				end
			end
			default: nxt_state = cssc_pkg::ST_IDLE;
		endcase

		// Completion: saturate the sum so a long accumulation never wraps to a small value
		if (finish) begin
			nxt_result = (sum[21:16] != 6'h00) ? 16'hFFFF : sum[15:0];
			nxt_done = 1'b1;
			nxt_acc = 22'h00_0000;
			nxt_cnt = 7'h00;
			nxt_state = cssc_pkg::ST_IDLE;
			// Continuous modes carry on only while the mode and enable are unchanged
			if (enable_ff && (trig == run_mode_ff)) begin
				case (run_mode_ff)
					cssc_pkg::TRIG_CONT_CHAN: begin
						nxt_chan = channel_select;
						nxt_state = cssc_pkg::ST_START;
					end
					cssc_pkg::TRIG_AUTO_SCAN: begin
						if (smen) begin
							nxt_masked = find_masked(channel_inclusion_mask, {1'b0, chan_ff} + 7'h01);
							if (!nxt_masked[6] || multi_ff) begin
								nxt_masked = first_masked;
							end
							if (nxt_masked[6]) begin
								nxt_chan = nxt_masked[5:0];
								nxt_state = cssc_pkg::ST_START;
							end
						end else begin
							nxt_chan = (chan_ff == last_ff) ? first_ff : chan_ff + 6'h01;
							nxt_state = cssc_pkg::ST_START;
						end
					end
					cssc_pkg::TRIG_SINGLE_SCAN: begin
						nxt_masked = find_masked(channel_inclusion_mask, {1'b0, chan_ff} + 7'h01);
						if (nxt_masked[6] && smen && !multi_ff) begin
							nxt_chan = nxt_masked[5:0];
							nxt_state = cssc_pkg::ST_START;
						end
					end
					default: nxt_state = cssc_pkg::ST_IDLE;
				endcase
			end
		end

		// Busy is registered so the port comes straight from a flop
		nxt_busy = nxt_state != cssc_pkg::ST_IDLE;

		// Read data; the done bit shows the held done_ff, not a set landing in the same cycle
		if (sfr_rd) begin
			case (sfr_addr)
				cssc_pkg::ADDR_CONTROL: nxt_rdata = {enable_ff, 1'b0, done_ff, state_ff != cssc_pkg::ST_IDLE,
					4'h0};
				cssc_pkg::ADDR_CONFIG: nxt_rdata = config_ff;
				cssc_pkg::ADDR_RESULT_HIGH: nxt_rdata = result_ff[15:8];
				cssc_pkg::ADDR_RESULT_LOW: nxt_rdata = result_ff[7:0];
				cssc_pkg::ADDR_SCAN_FIRST: nxt_rdata = {2'h0, first_ff};
				cssc_pkg::ADDR_SCAN_LAST: nxt_rdata = {2'h0, last_ff};
				default: nxt_rdata = cssc_pkg::RESET_VALUE;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= cssc_pkg::ST_IDLE;
			enable_ff <= 1'b0;
			done_ff <= 1'b0;
			config_ff <= cssc_pkg::RESET_VALUE;
			first_ff <= 6'h00;
			last_ff <= 6'h00;
			result_ff <= 16'h0000;
			chan_ff <= 6'h00;
			multi_ff <= 1'b0;
			run_mode_ff <= 3'h0;
			single_pend_ff <= 1'b0;
			acc_ff <= 22'h00_0000;
			cnt_ff <= 7'h00;
			start_ff <= 1'b0;
			rdata_ff <= cssc_pkg::RESET_VALUE;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			enable_ff <= nxt_enable;
			done_ff <= nxt_done;
			config_ff <= nxt_config;
			first_ff <= nxt_first;
			last_ff <= nxt_last;
			result_ff <= nxt_result;
			chan_ff <= nxt_chan;
			multi_ff <= nxt_multi;
			run_mode_ff <= nxt_run_mode;
			single_pend_ff <= nxt_single_pend;
			acc_ff <= nxt_acc;
			cnt_ff <= nxt_cnt;
			start_ff <= nxt_start;
			rdata_ff <= nxt_rdata;
			busy_ff <= nxt_busy;
		end
	end

	// Outputs straight from flip-flops
	assign sfr_rdata = rdata_ff;
	assign fe_start = start_ff;
	assign fe_channel = chan_ff;
	assign fe_multi = multi_ff;
	assign conversion_busy = busy_ff;
	assign conversion_done_flag = done_ff;
endmodule
`default_nettype wire

// ===== tb/cssc_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
module cssc_fe_model #(
	parameter logic [15:0] VAL = 16'h0321
) (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic slow, // Stretch each sample
	input wire logic fe_start, // Sample request
	output logic fe_done, // Sample finished
	output logic [15:0] fe_value // Sample value
);
	logic [2:0] cnt_ff;
	logic run_ff;
	logic done_ff;
	// Count down from each request, long or short
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_ff <= 1'b0;
			cnt_ff <= 3'h0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= run_ff && cnt_ff == 3'h0;
			if (fe_start) begin
				run_ff <= 1'b1;
				cnt_ff <= slow ? 3'h7 : 3'h1;
			end else if (run_ff) begin
				cnt_ff <= cnt_ff - 3'h1;
				if (cnt_ff == 3'h0)
					run_ff <= 1'b0;
			end
		end
	end
	assign fe_done = done_ff;
	// Off the done cycle the bus shows the inverse, so a late capture never matches
	assign fe_value = done_ff ? VAL : ~VAL;
endmodule
`default_nettype wire

// ===== tb/cssc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cssc_chk #(
	parameter int NCH = 64
) (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic [7:0] sfr_addr, // Address
	input wire logic sfr_wr, // Write strobe
	input wire logic [7:0] sfr_wdata, // Write data
	input wire logic [3:0] tmr_ovf, // Timer pulses
	input wire logic [NCH-1:0] channel_inclusion_mask, // Scan mask
	input wire logic [5:0] channel_select, // Single channel
	input wire logic fe_start, // Sample start
	input wire logic [5:0] fe_channel, // Sample channel
	input wire logic fe_done, // Sample done
	input wire logic conversion_busy, // Busy
	input wire logic conversion_done_flag // Done flag
);
	logic [7:0] cfg_ff, nxt_cfg;
	logic en_ff, nxt_en;
	logic [2:0] trig;
	logic [1:0] lane;
	logic ctl_wr, busy_wr;
	// Shadow of written settings, as the checker cannot see the registers
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_en = en_ff;
		if (sfr_wr && sfr_addr == cssc_pkg::ADDR_CONFIG)
			nxt_cfg = sfr_wdata & cssc_pkg::CFG_WRITE_MASK;
		if (ctl_wr)
			nxt_en = sfr_wdata[7];
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_ff <= 8'h00;
			en_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			en_ff <= nxt_en;
		end
	end
	assign trig = cfg_ff[6:4];
	assign lane = trig == 3'h1 ? 2'h0 : trig == 3'h2 ? 2'h2 : trig == 3'h3 ? 2'h1 : 2'h3;
	assign ctl_wr = sfr_wr && sfr_addr == cssc_pkg::ADDR_CONTROL;
	// The design starts on the enable already held alone; this check also asks for the one being written
	assign busy_wr = ctl_wr && en_ff && sfr_wdata[7] && sfr_wdata[4] && !conversion_busy;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_hold;
		!fe_start && $stable(fe_channel);
	endsequence
	sequence s_end;
		conversion_done_flag && !conversion_busy;
	endsequence
	wr_start_a: assert property (busy_wr && (trig == 3'h0 || trig == 3'h6 || trig == 3'h7 && !cfg_ff[7]) |=> fe_start && conversion_busy) else $error("busy write did not start");
	wr_refused_a: assert property (busy_wr && trig inside {[3'h1:3'h4]} && tmr_ovf == 4'h0 |=> !fe_start) else $error("busy write started in timer mode");
	tmr_start_a: assert property (trig inside {[3'h1:3'h4]} && en_ff && !conversion_busy && tmr_ovf[lane] && !sfr_wr |=> fe_start) else $error("timer overflow missed");
	tmr_other_a: assert property (trig inside {[3'h1:3'h4]} && !conversion_busy && !tmr_ovf[lane] && !sfr_wr |=> !fe_start) else $error("wrong timer started");
	done_set_a: assert property (trig == 3'h0 && cfg_ff[2:0] == 3'h0 && fe_done && conversion_busy |=> s_end) else $error("done not set");
	done_hold_a: assert property (conversion_done_flag && !(ctl_wr && !sfr_wdata[5]) |=> conversion_done_flag) else $error("done flag lost");
	chan_single_a: assert property (fe_start && trig == 3'h6 |-> fe_channel == channel_select) else $error("wrong single channel");
	chan_masked_a: assert property (fe_start && cfg_ff[7] && trig inside {3'h5, 3'h7} |-> channel_inclusion_mask[fe_channel]) else $error("unmasked channel");
	chan_hold_a: assert property (fe_start |=> s_hold) else $error("start not a pulse");
endmodule
bind cssc_top cssc_chk #(.NCH(NCH)) u_chk (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata), .tmr_ovf(tmr_ovf), .channel_inclusion_mask(channel_inclusion_mask),
	.channel_select(channel_select), .fe_start(fe_start), .fe_channel(fe_channel), .fe_done(fe_done),
	.conversion_busy(conversion_busy), .conversion_done_flag(conversion_done_flag));
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [15:0] VAL = 16'h0321;
	logic clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, slow = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic [3:0] tmr_ovf = 4'h0, lb;
	logic [63:0] mask = 64'h0000_0000_0000_0208;
	logic [5:0] channel_select = 6'h00, fe_channel;
	logic fe_start, fe_done, conversion_busy, conversion_done_flag, fe_multi;
	logic [15:0] fe_value, e;
	int miscompares = 0, cmp_count = 0, i;
	int nt[8] = '{1, 4, 8, 16, 32, 64, 1, 1};
	int ln[5] = '{0, 0, 2, 1, 3};
	logic [7:0] ra[6] = '{8'hAA, 8'hEE, 8'hED, 8'hDD, 8'hB0, 8'h55};
	always #5 clk = ~clk;
	cssc_top #(.NCH(64)) uut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tmr_ovf(tmr_ovf), .channel_inclusion_mask(mask),
		.channel_select(channel_select), .fe_start(fe_start), .fe_channel(fe_channel), .fe_multi(fe_multi),
		.fe_done(fe_done), .fe_value(fe_value), .conversion_busy(conversion_busy),
		.conversion_done_flag(conversion_done_flag));
	cssc_fe_model #(.VAL(VAL)) fe (.clk(clk), .sys_rst(sys_rst), .slow(slow), .fe_start(fe_start),
		.fe_done(fe_done), .fe_value(fe_value));
	task chk(input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	// Read data is registered, so it is taken just after the strobe edge
	task rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 chk({8'h00, sfr_rdata}, {8'h00, x});
	endtask
	task tmr(input logic [3:0] m);
		@(posedge clk);
		tmr_ovf <= m;
		@(posedge clk);
		tmr_ovf <= 4'h0;
	endtask
	task idle;
		int k;
		// Let a start taken at the calling edge show up before looking
		@(negedge clk);
		for (k = 0; k < 2000 && conversion_busy !== 1'b0; k++)
			@(negedge clk);
		chk({15'h0000, conversion_busy}, 16'h0000);
	endtask
	task expch(input logic [5:0] x);
		int k;
		k = 0;
		do @(negedge clk); while (fe_start !== 1'b1 && ++k < 400);
		chk({15'h0000, fe_start}, 16'h0001);
		chk({10'h000, fe_channel}, {10'h000, x});
	endtask
	task results;
		$display("compares %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog, well beyond the fewer than two thousand cycles the tests need
	initial begin
		#200us;
		miscompares++;
		results();
	end
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 6; i++)
			rd(ra[i], 8'h00);
		wr(8'hAA, 8'hFF);
		rd(8'hAA, 8'hF7);
		wr(8'hDD, 8'hFF);
		rd(8'hDD, 8'h3F);
		$display("test registers done");
		wr(8'hAA, 8'h00);
		wr(8'hB0, 8'h80);
		for (i = 0; i < 8; i++) begin
			slow <= i[0];
			wr(8'hAA, {5'h00, i[2:0]});
			wr(8'hB0, 8'h90);
			idle();
			e = 16'(VAL * nt[i]);
			rd(8'hEE, e[15:8]);
			rd(8'hED, e[7:0]);
			rd(8'hB0, 8'hA0);
			wr(8'hB0, 8'h80);
			rd(8'hB0, 8'h80);
		end
		$display("test accumulate done");
		for (i = 1; i < 5; i++) begin
			lb = 4'h1 << ln[i];
			wr(8'hAA, {1'b0, i[2:0], 4'h0});
			wr(8'hB0, 8'h90);
			repeat (3) @(negedge clk);
			chk({15'h0000, conversion_busy}, 16'h0000);
			tmr(~lb);
			repeat (3) @(negedge clk);
			chk({15'h0000, conversion_busy}, 16'h0000);
			tmr(lb);
			@(negedge clk);
			chk({15'h0000, conversion_busy}, 16'h0001);
			idle();
			rd(8'hB0, 8'hA0);
			wr(8'hB0, 8'h80);
		end
		$display("test timers done");
		channel_select <= 6'h05;
		wr(8'hAA, 8'h60);
		wr(8'hB0, 8'h90);
		expch(6'h05);
		expch(6'h05);
		wr(8'hB0, 8'h00);
		idle();
		wr(8'hDD, 8'h02);
		wr(8'hDE, 8'h04);
		wr(8'hAA, 8'h70);
		wr(8'hB0, 8'h80);
		wr(8'hB0, 8'h90);
		for (i = 0; i < 4; i++)
			expch(6'(2 + i % 3));
		wr(8'hB0, 8'h00);
		idle();
		$display("test continuous done");
		wr(8'hB0, 8'h80);
		// Bit 3 is read-only, so the scan must still step through both channels
		wr(8'hAA, 8'hF8);
		expch(6'h03);
		expch(6'h09);
		chk({15'h0000, fe_multi}, 16'h0000);
		expch(6'h03);
		wr(8'hAA, 8'h80);
		idle();
		wr(8'hAA, 8'hD0);
		expch(6'h03);
		expch(6'h09);
		idle();
		repeat (20) @(negedge clk);
		chk({15'h0000, conversion_busy}, 16'h0000);
		$display("test scans done");
		results();
	end
endmodule
`default_nettype wire
